// ### ssc_pkg.sv
// Constants, types and register map of the external start/stop control
package ssc_pkg;

   // ==========================================================
   // Register port
   localparam int          ADDR_W     = 5;
   localparam int          DATA_W     = 32;
   localparam logic [4:0]  OFF_CTRL   = 5'h00;
   localparam logic [4:0]  OFF_THRESH = 5'h04;
   localparam logic [4:0]  OFF_ASSIGN = 5'h08;
   localparam logic [4:0]  OFF_STATE  = 5'h0C;
   localparam logic [4:0]  OFF_IRQ_ST = 5'h10;
   localparam logic [4:0]  OFF_IRQ_MK = 5'h14;

   // ==========================================================
   // Control and assignment register fields
   localparam int          SRC_W        = 3;
   localparam int          CTRL_EXT_EN  = 0;
   localparam int          CTRL_LATCH   = 1;
   localparam int          CTRL_DIN_INV = 2;
   localparam int          CTRL_KEYLOCK = 3;
   localparam int          CTRL_REMOTE  = 4;
   localparam int          CTRL_SRC_LSB = 5;
   localparam int          ASSIGN_MASTER_LSB = 8;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [15:0] ASSIGN_RESET = 16'h0000;

   // ==========================================================
   // Interrupt status bits
   localparam int          IRQ_W       = 4;
   localparam int          IRQ_START   = 0;
   localparam int          IRQ_STOP    = 1;
   localparam int          IRQ_LOCK    = 2;
   localparam int          IRQ_SETERR  = 3;
   localparam logic [3:0]  IRQ_RESET   = 4'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_EXT_RUN = 2'b01,
      ST_MAN_RUN = 2'b10,
      ST_MAN_EXT = 2'b11
   } run_state_e;

   typedef enum logic [1:0] {
      LBL_START    = 2'b00,
      LBL_STOP     = 2'b01,
      LBL_EXT_STOP = 2'b10,
      LBL_EXTERNAL = 2'b11
   } mid_label_e;

   typedef struct packed {
      logic [SRC_W-1:0] src;
      logic             remote_speed_mode;
      logic             keylock;
      logic             din_inv;
      logic             latch;
      logic             ext_en;
   } cfg_s;

   typedef struct packed {
      logic [7:0] master_mask;
      logic [7:0] alarm_mask;
   } assign_s;

endpackage

// ### start_stop_ctrl.sv
// Run/stop decision logic for external and front-panel pump control
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module start_stop_ctrl #(
   parameter int ADC_W   = 12,
   parameter int NUM_AIN = 4,
   parameter int NUM_DIN = 2
) (
   // Clock and reset
   input  wire logic                        CLOCK,
   input  wire logic                        RST,
   // Register port
   input  wire logic [ssc_pkg::ADDR_W-1:0]  ADDR,
   input  wire logic [ssc_pkg::DATA_W-1:0]  WDATA,
   input  wire logic                        WR,
   input  wire logic                        RD,
   output logic      [ssc_pkg::DATA_W-1:0]  RDATA,
   // External sources
   input  wire logic [NUM_AIN-1:0][ADC_W-1:0] AIN,
   input  wire logic [NUM_DIN-1:0]          DIN,
   // Front panel and alarm
   input  wire logic                        KEY_MID,
   input  wire logic                        KEY_INC,
   input  wire logic                        KEY_DEC,
   input  wire logic                        ALARM_STOP,
   // Pump and display
   output logic                             PUMP_RUN,
   output ssc_pkg::mid_label_e              MID_LABEL,
   output logic                             INC_OUT,
   output logic                             DEC_OUT,
   output logic                             LOCK_NOTICE,
   output logic                             SETTING_ERR,
   output logic                             IRQ
);
   import ssc_pkg::*;

   // ==========================================================
   // Registers
   cfg_s                   cfg_ff;
   assign_s                asg_ff;
   logic [ADC_W-1:0]       thresh_ff;
   logic [IRQ_W-1:0]       irq_st_ff;
   logic [IRQ_W-1:0]       irq_mk_ff;
   logic [DATA_W-1:0]      rdata_ff;
   run_state_e             state_ff;
   run_state_e             nxt_state;
   logic                   lvl_ff;
   logic                   prev_ff;
   logic                   run_ff;
   logic                   inc_ff;
   logic                   dec_ff;
   logic                   lock_ff;
   logic                   err_ff;

   // ==========================================================
   // Register decode
   wire wr_ctrl   = WR && (ADDR == OFF_CTRL);
   wire wr_thresh = WR && (ADDR == OFF_THRESH);
   wire wr_assign = WR && (ADDR == OFF_ASSIGN);
   wire wr_irq_st = WR && (ADDR == OFF_IRQ_ST);
   wire wr_irq_mk = WR && (ADDR == OFF_IRQ_MK);

   // ==========================================================
   // Source selection
   logic [ADC_W-1:0] ain_val;
   logic             din_val;
   always_comb begin
      ain_val = '0;
      din_val = 1'b0;
      for (int i = 0; i < NUM_AIN; i++) begin
         if (cfg_ff.src == SRC_W'(i)) begin
            ain_val = AIN[i];
         end
      end
      for (int i = 0; i < NUM_DIN; i++) begin
         if (cfg_ff.src == SRC_W'(i + NUM_AIN)) begin
            din_val = DIN[i];
         end
      end
   end

   wire src_analog = (32'(cfg_ff.src) < NUM_AIN);
   wire src_valid  = (32'(cfg_ff.src) < NUM_AIN + NUM_DIN);
   // Threshold compare only for analog; digital uses pin level, inverted when din_inv is set
   wire lvl_now = src_analog ? (ain_val >= thresh_ff)
                             : (din_val ^ cfg_ff.din_inv);
   // A shared source would let an alarm and the run control fight
   wire conflict = cfg_ff.ext_en &&
                   (!src_valid ||
                    asg_ff.alarm_mask[cfg_ff.src] ||
                    asg_ff.master_mask[cfg_ff.src]);
   wire ext_ok = cfg_ff.ext_en && !conflict;

   // Edges of consecutive samples, one event per transition
   wire rise    = lvl_ff && !prev_ff;
   wire fall    = !lvl_ff && prev_ff;
   wire ext_on  = ext_ok && rise;
   // Latching stops on the next re-reach; plain stops on the drop
   wire ext_off = ext_ok && (cfg_ff.latch ? rise : fall);
   wire mid_act = KEY_MID && !cfg_ff.keylock;

   // ==========================================================
   // Run state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (ext_on) begin
               nxt_state = ST_EXT_RUN;
            end else if (mid_act) begin
               nxt_state = ST_MAN_RUN;
            end
         end
         ST_EXT_RUN: begin
            if (ext_off || mid_act) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_MAN_RUN: begin
            if (mid_act) begin
               nxt_state = ST_IDLE;
            end else if (ext_on) begin
               nxt_state = ST_MAN_EXT;
            end
         end
         ST_MAN_EXT: begin
            // Manual stop hands the run over to the external stop key
            if (mid_act) begin
               nxt_state = ST_EXT_RUN;
            end
         end
      endcase
      if (ALARM_STOP) begin
         nxt_state = ST_IDLE;
      end
   end

   wire nxt_run   = (nxt_state != ST_IDLE);
   wire start_ev  = nxt_run && !run_ff;
   wire stop_ev   = !nxt_run && run_ff;
   wire [IRQ_W-1:0] irq_set = {conflict, KEY_MID && cfg_ff.keylock,
                               stop_ev, start_ev};
   wire [IRQ_W-1:0] nxt_irq_st =
      (irq_st_ff & ~(wr_irq_st ? WDATA[IRQ_W-1:0] : IRQ_RESET)) | irq_set;

   // ==========================================================
   // Read mux
   wire [DATA_W-1:0] rd_mux =
      (ADDR == OFF_CTRL)   ? DATA_W'(cfg_ff) :
      (ADDR == OFF_THRESH) ? DATA_W'(thresh_ff) :
      (ADDR == OFF_ASSIGN) ? DATA_W'(asg_ff) :
      (ADDR == OFF_STATE)  ? DATA_W'({lvl_ff, conflict, run_ff, state_ff}) :
      (ADDR == OFF_IRQ_ST) ? DATA_W'(irq_st_ff) :
      (ADDR == OFF_IRQ_MK) ? DATA_W'(irq_mk_ff) : '0;

   // ==========================================================
   // Flip-flops
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cfg_ff    <= cfg_s'(CTRL_RESET);
         asg_ff    <= assign_s'(ASSIGN_RESET);
         thresh_ff <= '0;
         irq_mk_ff <= IRQ_RESET;
      end else begin
         if (wr_ctrl)   cfg_ff    <= cfg_s'(WDATA[7:0]);
         if (wr_assign) asg_ff    <= assign_s'(WDATA[15:0]);
         if (wr_thresh) thresh_ff <= WDATA[ADC_W-1:0];
         if (wr_irq_mk) irq_mk_ff <= WDATA[IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_ff  <= ST_IDLE;
         run_ff    <= 1'b0;
         lvl_ff    <= 1'b0;
         prev_ff   <= 1'b0;
         irq_st_ff <= IRQ_RESET;
         rdata_ff  <= '0;
      end else begin
         state_ff  <= nxt_state;
         run_ff    <= nxt_run;
         lvl_ff    <= lvl_now;
         prev_ff   <= lvl_ff;
         irq_st_ff <= nxt_irq_st;
         rdata_ff  <= RD ? rd_mux : '0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         inc_ff  <= 1'b0;
         dec_ff  <= 1'b0;
         lock_ff <= 1'b0;
         err_ff  <= 1'b0;
      end else begin
         inc_ff  <= KEY_INC && !cfg_ff.remote_speed_mode;
         dec_ff  <= KEY_DEC && !cfg_ff.remote_speed_mode;
         lock_ff <= KEY_MID && cfg_ff.keylock;
         err_ff  <= conflict;
      end
   end

   // ==========================================================
   // Outputs
   assign PUMP_RUN    = run_ff;
   assign MID_LABEL   = (cfg_ff.keylock && cfg_ff.ext_en) ? LBL_EXTERNAL :
                        (state_ff == ST_IDLE)    ? LBL_START :
                        (state_ff == ST_EXT_RUN) ? LBL_EXT_STOP : LBL_STOP;
   assign INC_OUT     = inc_ff;
   assign DEC_OUT     = dec_ff;
   assign LOCK_NOTICE = lock_ff;
   assign SETTING_ERR = err_ff;
   assign IRQ         = |(irq_st_ff & irq_mk_ff);
   assign RDATA       = rdata_ff;

   // ==========================================================
   // Checks
   a_nonlatch_stop: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_EXT_RUN && ext_ok && !cfg_ff.latch && fall)
      |=> !PUMP_RUN)
      else $error("non-latching fall did not stop pump");
   a_latch_toggle: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_EXT_RUN && ext_ok && cfg_ff.latch && rise)
      |=> !PUMP_RUN)
      else $error("latching rise did not stop pump");
   a_latch_hold: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_EXT_RUN && ext_ok && cfg_ff.latch && fall &&
       !mid_act && !ALARM_STOP)
      |=> PUMP_RUN)
      else $error("latching drop stopped pump");
   a_ext_start: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_IDLE && ext_on && !ALARM_STOP)
      |=> PUMP_RUN && state_ff == ST_EXT_RUN)
      else $error("external start not taken");
   a_manual_start: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_IDLE && mid_act && !ext_on && !ALARM_STOP)
      |=> PUMP_RUN && state_ff == ST_MAN_RUN)
      else $error("middle key did not start pump");
   a_conflict_block: assert property (
      @(posedge CLOCK) disable iff (RST)
      (conflict && state_ff == ST_IDLE && !KEY_MID)
      |=> state_ff == ST_IDLE && SETTING_ERR)
      else $error("conflicting source started pump");
   a_man_ignore: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_MAN_EXT && !KEY_MID && !ALARM_STOP)
      |=> state_ff == ST_MAN_EXT)
      else $error("external input acted during manual run");
   a_two_step_stop: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_MAN_EXT && mid_act && !ALARM_STOP)
      |=> PUMP_RUN && MID_LABEL != LBL_START)
      else $error("manual stop ended run with external start pending");
   a_lock_ignore: assert property (
      @(posedge CLOCK) disable iff (RST)
      (cfg_ff.keylock && KEY_MID && !ALARM_STOP && !ext_on && !ext_off)
      |=> $stable(PUMP_RUN) && LOCK_NOTICE)
      else $error("keylocked middle key changed run state");
   a_alarm_stop: assert property (
      @(posedge CLOCK) disable iff (RST)
      ALARM_STOP |=> !PUMP_RUN)
      else $error("alarm did not stop pump at once");
   a_ext_key_stop: assert property (
      @(posedge CLOCK) disable iff (RST)
      (state_ff == ST_EXT_RUN && mid_act) |=> !PUMP_RUN)
      else $error("external stop key did not stop pump");
   a_remote_keys: assert property (
      @(posedge CLOCK) disable iff (RST)
      (cfg_ff.remote_speed_mode && $past(cfg_ff.remote_speed_mode))
      |-> !INC_OUT && !DEC_OUT)
      else $error("speed keys active in remote speed mode");
   a_inc_pass: assert property (
      @(posedge CLOCK) disable iff (RST)
      (KEY_INC && !cfg_ff.remote_speed_mode) |=> INC_OUT)
      else $error("plus key lost outside remote speed mode");
   a_dec_pass: assert property (
      @(posedge CLOCK) disable iff (RST)
      (KEY_DEC && !cfg_ff.remote_speed_mode) |=> DEC_OUT)
      else $error("minus key lost outside remote speed mode");
   a_one_event: assert property (
      @(posedge CLOCK) disable iff (RST)
      rise |=> !rise)
      else $error("one transition gave two events");

   c_ext_cycle: cover property (@(posedge CLOCK) disable iff (RST)
      state_ff == ST_IDLE ##1 state_ff == ST_EXT_RUN
      ##[1:50] state_ff == ST_IDLE);
   c_two_step: cover property (@(posedge CLOCK) disable iff (RST)
      state_ff == ST_MAN_EXT ##1 state_ff == ST_EXT_RUN);
   c_lock: cover property (@(posedge CLOCK) disable iff (RST) LOCK_NOTICE);
   c_conflict: cover property (@(posedge CLOCK) disable iff (RST)
      SETTING_ERR);

endmodule

`default_nettype wire

// ### ext_source_model.sv
// Behavioural model of the external control system and foot pedal
`timescale 1ns/1ps
`default_nettype none

module ext_source_model #(
   parameter int ADC_W   = 12,
   parameter int NUM_AIN = 4,
   parameter int NUM_DIN = 2
) (
   // Clock
   input  wire logic                        CLOCK,
   // Source lines towards the block
   output var logic [NUM_AIN-1:0][ADC_W-1:0] AIN,
   output var logic [NUM_DIN-1:0]           DIN
);
   // ==========================================================
   // Lines start low, like an unpowered sensor and a released pedal
   initial begin
      AIN = '0;
      DIN = '0;
   end

   // ==========================================================
   // Changes land just after an edge, never on the sampling edge
   task automatic drive_ain(input int i, input logic [ADC_W-1:0] v);
      @(posedge CLOCK);
      AIN[i] <= v;
   endtask

   task automatic set_din(input int i, input logic v);
      @(posedge CLOCK);
      DIN[i] <= v;
   endtask

   // Pedal tap; a long hold models a slow foot
   task automatic pulse_din(input int i, input int len);
      @(posedge CLOCK);
      DIN[i] <= 1'b1;
      repeat (len) @(posedge CLOCK);
      DIN[i] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### start_stop_ctrl_tb.sv
// Self-checking testbench of the external start/stop control
`timescale 1ns/1ps
`default_nettype none

module start_stop_ctrl_tb;
   import ssc_pkg::*;
   // ==========================================================
   // Signals
   logic              clock, rst, wr, rd, alarm_stop;
   logic [4:0]        addr;
   logic [31:0]       wdata, rdata;
   logic [2:0]        keys;
   logic [3:0][11:0]  ain;
   logic [1:0]        din;
   logic              pump_run, inc_out, dec_out, lock_notice;
   logic              setting_err, irq;
   mid_label_e        mid_label;
   int                miscompares, tests_run;

   start_stop_ctrl start_stop_ctrl_inst (.CLOCK(clock), .RST(rst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .AIN(ain), .DIN(din), .KEY_MID(keys[0]), .KEY_INC(keys[1]),
      .KEY_DEC(keys[2]), .ALARM_STOP(alarm_stop), .PUMP_RUN(pump_run),
      .MID_LABEL(mid_label), .INC_OUT(inc_out), .DEC_OUT(dec_out),
      .LOCK_NOTICE(lock_notice), .SETTING_ERR(setting_err), .IRQ(irq));

   ext_source_model ext_source_model_inst (.CLOCK(clock), .AIN(ain),
      .DIN(din));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ==========================================================
   // Shared tasks
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic reset_dut();
      @(posedge clock);
      rst <= 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      idle(1);
   endtask

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   // Bounded wait; a run that never settles ends the test
   task automatic wait_run(input logic exp);
      int n;
      for (n = 0; n < 10; n++) begin
         idle(1);
         if (pump_run === exp) break;
      end
      check({31'h0, pump_run}, {31'h0, exp});
      if (n == 10) print_verdict();
   endtask

   task automatic press(input int k);
      @(posedge clock);
      keys <= 3'(1 << k);
      @(posedge clock);
      keys <= 3'h0;
      #1;
   endtask

   // ==========================================================
   // Scenarios
   task automatic sc_reset();
      for (int a = 0; a < 28; a += 4) if (a != 12) rreg(5'(a), 32'h0);
      check({30'h0, mid_label}, {30'h0, LBL_START});
   endtask

   task automatic sc_analog();
      reset_dut();
      ext_source_model_inst.drive_ain(1, 12'h7FF);
      wreg(OFF_THRESH, 32'h800);
      rreg(OFF_THRESH, 32'h800);
      wreg(OFF_CTRL, 32'h21);
      idle(5);
      check({31'h0, pump_run}, 32'h0);
      ext_source_model_inst.drive_ain(1, 12'h800);
      wait_run(1'b1);
      ext_source_model_inst.drive_ain(1, 12'h7FF);
      wait_run(1'b0);
      rreg(OFF_IRQ_ST, 32'h3);
      check({31'h0, irq}, 32'h0);
      wreg(OFF_IRQ_MK, 32'h2);
      idle(1);
      check({31'h0, irq}, 32'h1);
      wreg(OFF_IRQ_ST, 32'h2);
      idle(1);
      check({31'h0, irq}, 32'h0);
      rreg(OFF_IRQ_ST, 32'h1);
   endtask

   task automatic sc_digital();
      reset_dut();
      ext_source_model_inst.set_din(0, 1'b1);
      wreg(OFF_CTRL, 32'h85);
      idle(5);
      check({31'h0, pump_run}, 32'h0);
      ext_source_model_inst.set_din(0, 1'b0);
      wait_run(1'b1);
      ext_source_model_inst.set_din(0, 1'b1);
      wait_run(1'b0);
   endtask

   task automatic sc_latch();
      reset_dut();
      ext_source_model_inst.set_din(1, 1'b0);
      wreg(OFF_CTRL, 32'hA3);
      ext_source_model_inst.pulse_din(1, 1);
      wait_run(1'b1);
      idle(5);
      check({31'h0, pump_run}, 32'h1);
      ext_source_model_inst.pulse_din(1, 3);
      wait_run(1'b0);
      ext_source_model_inst.drive_ain(0, 12'h000);
      wreg(OFF_THRESH, 32'h100);
      wreg(OFF_CTRL, 32'h03);
      ext_source_model_inst.drive_ain(0, 12'h100);
      wait_run(1'b1);
      ext_source_model_inst.drive_ain(0, 12'h0FF);
      idle(5);
      check({31'h0, pump_run}, 32'h1);
      ext_source_model_inst.drive_ain(0, 12'h100);
      wait_run(1'b0);
   endtask

   task automatic sc_panel();
      reset_dut();
      ext_source_model_inst.set_din(0, 1'b0);
      wreg(OFF_CTRL, 32'h81);
      idle(2);
      check({30'h0, mid_label}, {30'h0, LBL_START});
      press(0);
      wait_run(1'b1);
      check({30'h0, mid_label}, {30'h0, LBL_STOP});
      ext_source_model_inst.set_din(0, 1'b1);
      idle(5);
      check({30'h0, mid_label}, {30'h0, LBL_STOP});
      press(0);
      idle(3);
      check({31'h0, pump_run}, 32'h1);
      check({30'h0, mid_label}, {30'h0, LBL_EXT_STOP});
      press(0);
      wait_run(1'b0);
      press(1);
      check({31'h0, inc_out}, 32'h1);
      press(2);
      check({31'h0, dec_out}, 32'h1);
      wreg(OFF_CTRL, 32'h91);
      press(2);
      check({31'h0, dec_out}, 32'h0);
      press(1);
      check({31'h0, inc_out}, 32'h0);
   endtask

   task automatic sc_lock();
      reset_dut();
      ext_source_model_inst.set_din(0, 1'b0);
      wreg(OFF_CTRL, 32'h89);
      idle(2);
      check({30'h0, mid_label}, {30'h0, LBL_EXTERNAL});
      press(0);
      check({31'h0, lock_notice}, 32'h1);
      idle(4);
      check({31'h0, pump_run}, 32'h0);
      rreg(OFF_IRQ_ST, 32'h4);
      // Keylock must not let the middle key stop an external run
      ext_source_model_inst.set_din(0, 1'b1);
      wait_run(1'b1);
      press(0);
      idle(3);
      check({31'h0, pump_run}, 32'h1);
      check({30'h0, mid_label}, {30'h0, LBL_EXTERNAL});
   endtask

   // Sources claimed by an alarm, then by the master sensor
   task automatic sc_conflict();
      for (int i = 0; i < 2; i++) begin
         reset_dut();
         ext_source_model_inst.drive_ain(2 + i, 12'h000);
         wreg(OFF_THRESH, 32'h100);
         wreg(OFF_ASSIGN, i ? 32'h800 : 32'h4);
         wreg(OFF_CTRL, i ? 32'h61 : 32'h41);
         ext_source_model_inst.drive_ain(2 + i, 12'hFFF);
         idle(6);
         check({31'h0, setting_err}, 32'h1);
         check({31'h0, pump_run}, 32'h0);
         rreg(OFF_IRQ_ST, 32'h8);
      end
      // An unused source code is refused as well
      wreg(OFF_ASSIGN, 32'h0);
      idle(1);
      check({31'h0, setting_err}, 32'h0);
      wreg(OFF_CTRL, 32'hC1);
      idle(2);
      check({31'h0, setting_err}, 32'h1);
   endtask

   task automatic sc_alarm();
      reset_dut();
      ext_source_model_inst.set_din(0, 1'b0);
      wreg(OFF_CTRL, 32'h81);
      ext_source_model_inst.set_din(0, 1'b1);
      wait_run(1'b1);
      @(posedge clock);
      alarm_stop <= 1'b1;
      @(posedge clock);
      alarm_stop <= 1'b0;
      #1;
      check({31'h0, pump_run}, 32'h0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      keys = 3'h0;
      alarm_stop = 1'b0;
      miscompares = 0;
      tests_run = 0;
      reset_dut();
      sc_reset();
      sc_analog();
      sc_digital();
      sc_latch();
      sc_panel();
      sc_lock();
      sc_conflict();
      sc_alarm();
      print_verdict();
   end
endmodule
`default_nettype wire
